/* File: pexio_pkg.sv */
package pexio_pkg;
  // axi4-lite register byte offsets
  localparam logic [3:0] PEXIO_OFS_MASK   = 4'h0;
  localparam logic [3:0] PEXIO_OFS_STATUS = 4'h4;
  localparam logic [3:0] PEXIO_OFS_LATCH  = 4'h8;
  localparam logic [1:0] PEXIO_RESP_OKAY  = 2'h0;
  localparam logic [1:0] PEXIO_RESP_ERR   = 2'h2;
  // reset values
  localparam logic [7:0] PEXIO_MASK_RST   = 8'h3C;
  localparam logic [7:0] PEXIO_LATCH_RST  = 8'hFF;
  // status word field positions
  localparam int         PEXIO_ST_LVL_LSB = 0;
  localparam int         PEXIO_ST_FLG_LSB = 8;
  localparam int         PEXIO_ST_ALERT   = 12;
  // address-select pin codes and target address prefix
  localparam logic [1:0] PEXIO_SEL_GND    = 2'h0;
  localparam logic [1:0] PEXIO_SEL_SCL    = 2'h2;
  localparam logic [2:0] PEXIO_ADDR_PFX   = 3'h6;
  // serial bit counts and strap settle time in cycles
  localparam logic [3:0] PEXIO_BITS_BYTE  = 4'h8;
  localparam logic [3:0] PEXIO_BITS_LAST  = 4'h7;
  localparam logic [1:0] PEXIO_STRAP_CYC  = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
  } pexio_state_t;
endpackage

/* File: pexio_core.sv */
`timescale 1ns/1ps
`default_nettype none
module pexio_core
  import pexio_pkg::*;
(
  // clock and power-on reset
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // two-wire bus
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output var  logic        sda_o,
  output var  logic        sda_oe_o,
  input  wire logic        bus_abort_n_i,
  // address-select pins, four-level code
  input  wire logic [1:0]  addr_sel_low_i,
  input  wire logic [1:0]  addr_sel_high_i,
  // open-drain ports, bit 0 is port two
  input  wire logic [3:0]  od_io_ports_i,
  output var  logic [3:0]  od_io_ports_o,
  output var  logic [3:0]  od_io_ports_oe_o,
  output var  logic [3:0]  pullup_en_o,
  // push-pull outputs and alert
  output var  logic        pp_out_zero_o,
  output var  logic        pp_out_one_o,
  output var  logic        pp_out_six_o,
  output var  logic        pp_out_seven_o,
  output var  logic        alert_n_o
);
  logic [2:0]   scl_s;
  logic [2:0]   sda_s;
  logic [1:0]   abort_s;
  logic [2:0]   pin_s [4];
  logic [1:0]   sel_lo_s [2];
  logic [1:0]   sel_hi_s [2];
  logic [3:0]   chg;
  logic [3:0]   flags;
  logic [3:0]   flag_snap;
  logic [7:0]   mask;
  logic [7:0]   out_latch;
  logic [2:0]   strap_cnt;
  logic         strap_done;
  logic         sel_lo_on;
  logic         sel_hi_on;
  logic [6:0]   dev_addr;
  logic [7:0]   pin_lvl;
  pexio_state_t state;
  logic [3:0]   bit_cnt;
  logic [7:0]   shift;
  logic [7:0]   tx;
  logic         rw;
  logic         nack;
  logic         byte_sel;
  logic         acc;
  logic         wr_pulse;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_c;
  logic         stop_c;
  logic         aw_got;
  logic         w_got;
  logic [3:0]   aw_addr;
  logic [7:0]   w_data;
  logic         w_strb0;

  // synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_s   <= 3'h7;
      sda_s   <= 3'h7;
      abort_s <= 2'h3;
    end else begin
      scl_s   <= {scl_s[1:0], scl_i};
      sda_s   <= {sda_s[1:0], sda_i};
      abort_s <= {abort_s[0], bus_abort_n_i};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          pin_s[g] <= 3'h0;
        end else begin
          pin_s[g] <= {pin_s[g][1:0], od_io_ports_i[g]};
        end
      end
      // neither the first samples nor the strap drive of our own pins count as changes
      assign chg[g] = (&strap_cnt) & (pin_s[g][1] ^ pin_s[g][2]);
    end
    for (g = 0; g < 2; g++) begin : g_sel
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sel_lo_s[g] <= PEXIO_SEL_GND;
          sel_hi_s[g] <= PEXIO_SEL_GND;
        end else if (g == 0) begin
          sel_lo_s[g] <= addr_sel_low_i;
          sel_hi_s[g] <= addr_sel_high_i;
        end else begin
          sel_lo_s[g] <= sel_lo_s[0];
          sel_hi_s[g] <= sel_hi_s[0];
        end
      end
    end
  endgenerate

  assign sel_lo_on = sel_lo_s[1] != PEXIO_SEL_GND;
  assign sel_hi_on = sel_hi_s[1] != PEXIO_SEL_GND;
  assign dev_addr  = {PEXIO_ADDR_PFX, sel_hi_s[1] ^ PEXIO_SEL_SCL, sel_lo_s[1]};
  assign pin_lvl   = {out_latch[7:6], pin_s[3][2], pin_s[2][2], pin_s[1][2], pin_s[0][2],
                      out_latch[1:0]};
  assign scl_rise  = scl_s[1] & ~scl_s[2];
  assign scl_fall  = ~scl_s[1] & scl_s[2];
  assign start_c   = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_c    = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  // strap capture after reset release; reasserted reset recaptures
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_cnt  <= 3'h0;
      strap_done <= 1'b0;
    end else begin
      // counts on past the strap so detection waits until the strap levels cleared the pin sync
      if (!(&strap_cnt)) begin
        strap_cnt <= strap_cnt + 3'h1;
      end
      if (strap_cnt == {1'b0, PEXIO_STRAP_CYC}) begin
        strap_done <= 1'b1;
      end
    end
  end

  // output latches and pin drive
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_latch        <= PEXIO_LATCH_RST;
      od_io_ports_oe_o <= 4'h0;
      pullup_en_o      <= 4'h0;
    end else if (!strap_done) begin
      out_latch        <= {{4{sel_hi_on}}, {4{sel_lo_on}}};
      od_io_ports_oe_o <= ~{{2{sel_hi_on}}, {2{sel_lo_on}}};
      pullup_en_o      <= {{2{sel_hi_on}}, {2{sel_lo_on}}};
    end else begin
      pullup_en_o <= {{2{sel_hi_on}}, {2{sel_lo_on}}};
      if (wr_pulse) begin
        out_latch        <= shift;
        od_io_ports_oe_o <= ~shift[5:2];
      end
    end
  end
  assign od_io_ports_o  = 4'h0;
  assign pp_out_zero_o  = out_latch[0];
  assign pp_out_one_o   = out_latch[1];
  assign pp_out_six_o   = out_latch[6];
  assign pp_out_seven_o = out_latch[7];

  // change flags: a change in the clearing cycle survives
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flags     <= 4'h0;
      flag_snap <= 4'h0;
    end else begin
      flags <= (flags & ~{4{acc}}) | chg;
      if (acc) begin
        flag_snap <= flags | chg;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alert_n_o <= 1'b1;
    end else begin
      alert_n_o <= ~|(flags & mask[5:2]);
    end
  end

  // serial slave
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      shift    <= 8'h00;
      tx       <= 8'h00;
      rw       <= 1'b0;
      nack     <= 1'b0;
      byte_sel <= 1'b0;
      acc      <= 1'b0;
      wr_pulse <= 1'b0;
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
    end else begin
      acc      <= 1'b0;
      wr_pulse <= 1'b0;
      if (!abort_s[1]) begin
        state    <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        state    <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_c) begin
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_o <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == PEXIO_BITS_BYTE) begin
              if (state == ST_WR) begin
                state    <= ST_WACK;
                sda_oe_o <= 1'b1;
                wr_pulse <= 1'b1;
              end else if (shift[7:1] == dev_addr) begin
                state    <= ST_AACK;
                sda_oe_o <= 1'b1;
                rw       <= shift[0];
                acc      <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_fall) begin
              bit_cnt  <= 4'h0;
              byte_sel <= 1'b0;
              if (state == ST_AACK && rw) begin
                state    <= ST_RD;
                tx       <= pin_lvl;
                sda_oe_o <= ~pin_lvl[7];
              end else begin
                state    <= ST_WR;
                sda_oe_o <= 1'b0;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 4'h1;
              tx      <= {tx[6:0], 1'b0};
              if (bit_cnt == PEXIO_BITS_LAST) begin
                state    <= ST_RACK;
                sda_oe_o <= 1'b0;
              end else begin
                sda_oe_o <= ~tx[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack <= sda_s[1];
            end else if (scl_fall) begin
              if (nack) begin
                state <= ST_IDLE;
              end else begin
                state    <= ST_RD;
                bit_cnt  <= 4'h0;
                byte_sel <= ~byte_sel;
                // next byte alternates levels and flags
                tx       <= byte_sel ? pin_lvl : {2'h0, flag_snap, 2'h0};
                sda_oe_o <= byte_sel ? ~pin_lvl[7] : 1'b1;
              end
            end
          end
          default: begin
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // axi4-lite write path
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 8'h00;
      w_strb0       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= PEXIO_RESP_OKAY;
      mask          <= PEXIO_MASK_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got   <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_strb0 <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
      end else if (aw_got && w_got && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == PEXIO_OFS_MASK) begin
          s_axi_bresp <= PEXIO_RESP_OKAY;
          if (w_strb0) begin
            mask <= w_data;
          end
        end else begin
          s_axi_bresp <= PEXIO_RESP_ERR;
        end
      end
    end
  end
  assign s_axi_awready = ~aw_got;
  assign s_axi_wready  = ~w_got;

  // axi4-lite read path
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= PEXIO_RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= PEXIO_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      case (s_axi_araddr)
        PEXIO_OFS_MASK: begin
          s_axi_rdata[7:0] <= mask;
        end
        PEXIO_OFS_STATUS: begin
          s_axi_rdata[PEXIO_ST_LVL_LSB +: 8] <= pin_lvl;
          s_axi_rdata[PEXIO_ST_FLG_LSB +: 4] <= flags;
          s_axi_rdata[PEXIO_ST_ALERT]        <= ~alert_n_o;
        end
        PEXIO_OFS_LATCH: begin
          s_axi_rdata[7:0] <= out_latch;
        end
        default: begin
          s_axi_rresp <= PEXIO_RESP_ERR;
        end
      endcase
    end
  end
  assign s_axi_arready = ~s_axi_rvalid;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_FLAG_SET: assert property (chg[0] |=> flags[0])
    else $error("change did not set its flag");
  AST_FLAG_CLR: assert property (acc && chg == 4'h0 |=> flags == 4'h0)
    else $error("access did not clear flags");
  AST_ALERT_SET: assert property ((flags & mask[5:2]) != 4'h0 |=> !alert_n_o)
    else $error("alert not asserted on flagged change");
  AST_ALERT_REL: assert property (acc && chg == 4'h0 ##1 chg == 4'h0 |=> alert_n_o)
    else $error("alert not released after access");
  AST_ABORT_IDLE: assert property (!abort_s[1] |=> state == ST_IDLE && !sda_oe_o)
    else $error("abort did not idle the bus interface");
  AST_ABORT_ALERT: assert property (!abort_s[1] && !alert_n_o ##1 !acc |=> !alert_n_o)
    else $error("abort released the alert");
  AST_ADDR: assert property ($rose(state == ST_AACK) |-> $past(shift[7:1]) == dev_addr)
    else $error("acknowledged a foreign address");
  AST_WRITE: assert property (wr_pulse && strap_done |=> out_latch == $past(shift))
    else $error("write byte not latched");

  COV_WRITE: cover property (wr_pulse);
  COV_READ2: cover property (state == ST_RD && byte_sel);
  COV_ABORT: cover property (!abort_s[1] && state != ST_IDLE);
  COV_ALERT: cover property ($fell(alert_n_o));
endmodule
`default_nettype wire

/* File: pexio_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none
module pexio_i2c_master (
  // two-wire bus; sda open drain, scl driven high and low
  output var  logic scl_o,
  output var  logic sda_low_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // data moves late in the low half so the slave's slower view of scl never sees a false start
  task automatic bit_io(input logic b, output logic s);
    scl_o = 1'b0;
    #20;
    sda_low_o = ~b;
    #4;
    scl_o = 1'b1;
    #12;
    s = sda_i;
    #12;
  endtask
  task automatic start();
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    #24;
    sda_low_o = 1'b1;
    #24;
  endtask
  task automatic stop();
    scl_o = 1'b0;
    #20;
    sda_low_o = 1'b1;
    #4;
    scl_o = 1'b1;
    #24;
    sda_low_o = 1'b0;
    #24;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack_n);
  endtask
  task automatic rbyte(output logic [7:0] d, input logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(ack_n, s);
  endtask
endmodule
`default_nettype wire

/* File: port_expander_io_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module port_expander_io_core_tb;
  import pexio_pkg::*;
  logic        sys_clk_i = 1'b0, arst_n_i = 1'b0, bus_abort_n_i = 1'b1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, ext = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [1:0]  sel_lo = 2'h0, sel_hi = 2'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        scl, sda_low, sda_oe, pp0, pp1, pp6, pp7, alert_n;
  logic [3:0]  oe, pu_en;
  wire logic   sda_line = ~(sda_low | sda_oe);
  wire logic [3:0] pins = ext & ~oe;
  wire logic [7:0] out_byte = {pp7, pp6, ~oe, pp1, pp0};
  int          num_errors = 0, tests_run = 0, seed = 96023;
  pexio_core i_dut (.sys_clk_i, .arst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe),
    .bus_abort_n_i, .addr_sel_low_i(sel_lo), .addr_sel_high_i(sel_hi), .od_io_ports_i(pins),
    .od_io_ports_o(), .od_io_ports_oe_o(oe), .pullup_en_o(pu_en), .pp_out_zero_o(pp0),
    .pp_out_one_o(pp1), .pp_out_six_o(pp6), .pp_out_seven_o(pp7), .alert_n_o(alert_n));
  pexio_i2c_master i_master (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_line));
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [7:0] lvl(input logic [7:0] l, input logic [3:0] e);
    return {l[7:6], e & l[5:2], l[1:0]};
  endfunction
  function automatic logic [7:0] strap(input logic [1:0] lo, input logic [1:0] hi);
    return {{4{hi != 2'h0}}, {4{lo != 2'h0}}};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    @(posedge sys_clk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic i2c_wr(input logic [6:0] a, input logic [7:0] d, output logic [1:0] ak);
    i_master.start();
    i_master.wbyte({a, 1'b0}, ak[1]);
    i_master.wbyte(d, ak[0]);
    i_master.stop();
  endtask
  initial begin
    #200us;
    num_errors++;
    summarize();
  end
  initial begin
    logic [31:0] rd;
    logic [1:0]  rs, ak, lo, hi;
    logic [7:0]  d, b1, b2;
    logic [3:0]  chg;
    logic [6:0]  adr;
    // every select code on both pins; each pass after the first also re-enters reset after a write
    for (int k = 0; k < 4; k++) begin
      lo = k[1:0];
      hi = k[1:0] + 2'h1;
      sel_lo <= lo;
      sel_hi <= hi;
      do_reset();
      chk(pu_en, {{2{hi != 2'h0}}, {2{lo != 2'h0}}});
      chk(out_byte, strap(lo, hi));
      chk(alert_n, 1'b1);
      axi_rd(PEXIO_OFS_MASK, rd, rs);
      chk(rd[7:0], PEXIO_MASK_RST);
      adr = {PEXIO_ADDR_PFX, hi ^ PEXIO_SEL_SCL, lo};
      d = $random(seed);
      i2c_wr(adr, d, ak);
      chk(ak, 2'h0);
      chk(out_byte, d);
      i2c_wr(adr ^ 7'h10, ~d, ak);
      chk(ak, 2'h3);
      chk(out_byte, d);
    end
    axi_wr(PEXIO_OFS_MASK, 32'hA5, rs);
    axi_rd(PEXIO_OFS_MASK, rd, rs);
    chk(rd[7:0], 8'hA5);
    axi_wr(PEXIO_OFS_LATCH, 32'h0, rs);
    chk(rs, PEXIO_RESP_ERR);
    axi_rd(4'hC, rd, rs);
    chk(rd, 32'h0);
    chk(rs, PEXIO_RESP_ERR);
    axi_wr(PEXIO_OFS_MASK, {24'h0, PEXIO_MASK_RST}, rs);
    ext <= $random(seed);
    d = $random(seed);
    d[5:2] = 4'hF;
    i2c_wr(adr, d, ak);
    i2c_wr(adr, d, ak);
    repeat (10) @(posedge sys_clk_i);
    chk(alert_n, 1'b1);
    // a brief pulse on the pins must still leave its flags and the alert behind
    chg = $random(seed);
    if (chg == 4'h0) chg = 4'h5;
    @(posedge sys_clk_i);
    ext <= ext ^ chg;
    repeat (3) @(posedge sys_clk_i);
    ext <= ext ^ chg;
    repeat (10) @(posedge sys_clk_i);
    chk(alert_n, 1'b0);
    axi_rd(PEXIO_OFS_STATUS, rd, rs);
    chk(rd[11:0], {chg, lvl(d, ext)});
    i_master.start();
    i_master.wbyte({adr, 1'b1}, ak[1]);
    i_master.rbyte(b1, 1'b0);
    i_master.rbyte(b2, 1'b1);
    i_master.stop();
    chk({ak[1], b1}, {1'b0, lvl(d, ext)});
    chk(b2, {2'b00, chg, 2'b00});
    chk(alert_n, 1'b1);
    axi_rd(PEXIO_OFS_STATUS, rd, rs);
    chk(rd[11:8], 4'h0);
    // abort in mid byte: no ack, latch kept, fresh alert survives
    i_master.start();
    i_master.wbyte({adr, 1'b0}, ak[1]);
    fork
      i_master.wbyte(~d, ak[0]);
      begin
        repeat (20) @(posedge sys_clk_i);
        ext <= ext ^ 4'h1;
        repeat (20) @(posedge sys_clk_i);
        bus_abort_n_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        bus_abort_n_i <= 1'b1;
      end
    join
    i_master.stop();
    chk(ak, 2'h1);
    chk(out_byte, d);
    chk(alert_n, 1'b0);
    i2c_wr(adr, d, ak);
    chk(ak, 2'h0);
    chk(alert_n, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
